/* psrc_pkg.sv */
// Package: offsets, field layouts and reset values of the reset controls
package psrc_pkg;
    localparam logic [11:0] RST_CTL_B_OFFSET = 12'h044;
    localparam logic [11:0] RST_CTL_C_OFFSET = 12'h048;
    localparam logic [11:0] CAP_MASK_B_OFFSET = 12'h010;
    localparam logic [11:0] CAP_MASK_D_OFFSET = 12'h01C;
    localparam logic [31:0] RST_CTL_B_RESET = 32'h0000_0000;
    localparam logic [31:0] RST_CTL_C_RESET = 32'h0000_0000;
    localparam logic [31:0] RST_CTL_B_IMPL = 32'h030F_5037;
    localparam logic [31:0] RST_CTL_C_IMPL = 32'h0001_20FF;
    localparam logic [31:0] CAP_MASK_B_DEFAULT = 32'h030F_5037;
    localparam logic [31:0] CAP_MASK_D_DEFAULT = 32'h0001_20FF;
    localparam int CMP_LSB = 24;
    localparam int TMR_LSB = 16;
    localparam int TW0_BIT = 12;
    localparam int TW1_BIT = 14;
    localparam int SSI_LSB = 4;
    localparam int ASY_LSB = 0;
    localparam int USB_BIT = 16;
    localparam int DMA_BIT = 13;
    localparam int PORT_LSB = 0;
    localparam int NUM_PORTS = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* psrc_ctl_reg.sv */
// Masked reset control register with read-only unused bits
`timescale 1ns/1ps
`default_nettype none
module psrc_ctl_reg #(
    parameter logic [31:0] IMPL  = 32'h0000_0000,
    parameter logic [31:0] RST_V = 32'h0000_0000
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_we,
    input  wire logic [31:0] i_wdata,
    input  wire logic [31:0] i_cap_mask,
    output logic      [31:0] o_value
);
    logic [31:0] value_r;
    logic [31:0] value_nxt;
    logic [31:0] wmask;

    // Only present peripherals and implemented positions take a write
    assign wmask = i_cap_mask & IMPL;
    assign value_nxt = (value_r & ~wmask) | (i_wdata & wmask);

    // Controls clear on system reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            value_r <= RST_V;
        end else if (i_we) begin
            value_r <= value_nxt;
        end
    end

    // Unused positions can never hold a one, so read as zero
    assign o_value = value_r & IMPL;
endmodule
`default_nettype wire

/* psrc_rst_out.sv */
// Registered fan-out of one control register onto peripheral resets
`timescale 1ns/1ps
`default_nettype none
module psrc_rst_out (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [31:0] i_value,
    output logic      [31:0] o_rst
);
    // Registered so reset lines are glitch free
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rst <= 32'h0000_0000;
        end else begin
            o_rst <= i_value;
        end
    end
endmodule
`default_nettype wire

/* psrc_top.sv */
// Peripheral soft reset controls behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Writes to control B are masked by capability mask B.
// - Writes to control C are masked by capability mask D.
// - Control B bits 25 and 24 reset comparators one and zero.
// - Control B bits 19 down to 16 reset timers three through zero.
// - Control B: two-wire 14,12; sync serial 5,4; async serial 2-0.
// - Control C bit 16 resets USB, bit 13 resets DMA engine.
// - Control C bits 7 down to 0 reset ports H through A.
// - Unused bits read zero, ignore writes; software preserves them.
module psrc_top #(
    parameter logic [31:0] CAP_B = psrc_pkg::CAP_MASK_B_DEFAULT,
    parameter logic [31:0] CAP_D = psrc_pkg::CAP_MASK_D_DEFAULT
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_HSEL,
    input  wire logic [11:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic             O_COMPARATOR_ZERO_RST,
    output logic             O_COMPARATOR_ONE_RST,
    output logic      [3:0]  O_GP_TMR_RST,
    output logic             O_TWO_WIRE_ZERO_RST,
    output logic             O_TWO_WIRE_ONE_RST,
    output logic             O_SYNC_SERIAL_ZERO_RST,
    output logic             O_SYNC_SERIAL_ONE_RST,
    output logic      [2:0]  O_ASYNC_SERIAL_RST,
    output logic             O_USB_UNIT_RST,
    output logic             O_DMA_ENGINE_RST,
    output logic      [7:0]  O_PORT_RST
);
    logic        wr_pend_r;
    logic [11:0] addr_r;
    logic        addr_phase;
    logic        we_b;
    logic        we_c;
    logic [31:0] ctl_b;
    logic [31:0] ctl_c;
    logic [31:0] rst_b;
    logic [31:0] rst_c;
    logic [31:0] rdata_nxt;

    // Whole-word transfer accepted in address phase
    assign addr_phase = I_HSEL && I_HREADY && I_HTRANS[1]
                        && (I_HSIZE == psrc_pkg::HSIZE_WORD);

    // Capture write address; data arrives one cycle later
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 12'h000;
        end else begin
            wr_pend_r <= addr_phase && I_HWRITE;
            addr_r    <= I_HADDR;
        end
    end

    assign we_b = wr_pend_r && (addr_r == psrc_pkg::RST_CTL_B_OFFSET);
    assign we_c = wr_pend_r && (addr_r == psrc_pkg::RST_CTL_C_OFFSET);

    // Control B gated by capability mask B
    psrc_ctl_reg #(
        .IMPL  (psrc_pkg::RST_CTL_B_IMPL),
        .RST_V (psrc_pkg::RST_CTL_B_RESET)
    ) u_ctl_b (
        .i_clk      (I_CORE_CLK),
        .i_rst_n    (I_RST_N),
        .i_we       (we_b),
        .i_wdata    (I_HWDATA),
        .i_cap_mask (CAP_B),
        .o_value    (ctl_b)
    );

    // Control C gated by capability mask D
    psrc_ctl_reg #(
        .IMPL  (psrc_pkg::RST_CTL_C_IMPL),
        .RST_V (psrc_pkg::RST_CTL_C_RESET)
    ) u_ctl_c (
        .i_clk      (I_CORE_CLK),
        .i_rst_n    (I_RST_N),
        .i_we       (we_c),
        .i_wdata    (I_HWDATA),
        .i_cap_mask (CAP_D),
        .o_value    (ctl_c)
    );

    // Read mux; mask addresses read CAP_B and CAP_D, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (I_HADDR == psrc_pkg::RST_CTL_B_OFFSET) begin
            rdata_nxt = ctl_b;
        end else if (I_HADDR == psrc_pkg::RST_CTL_C_OFFSET) begin
            rdata_nxt = ctl_c;
        end else if (I_HADDR == psrc_pkg::CAP_MASK_B_OFFSET) begin
            rdata_nxt = CAP_B;
        end else if (I_HADDR == psrc_pkg::CAP_MASK_D_OFFSET) begin
            rdata_nxt = CAP_D;
        end
    end

    // Read data registered in address phase, stands in data phase
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            O_HRDATA <= 32'h0000_0000;
        end else if (addr_phase && !I_HWRITE) begin
            O_HRDATA <= rdata_nxt;
        end
    end

    // Zero wait states, always OKAY
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;

    // Registered reset lines, one cycle after the control changes
    psrc_rst_out u_out_b (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_value (ctl_b),
        .o_rst   (rst_b)
    );

    psrc_rst_out u_out_c (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_value (ctl_c),
        .o_rst   (rst_c)
    );

    // Peripheral reset mapping of control B
    assign O_COMPARATOR_ZERO_RST  = rst_b[psrc_pkg::CMP_LSB];
    assign O_COMPARATOR_ONE_RST   = rst_b[psrc_pkg::CMP_LSB + 1];
    assign O_GP_TMR_RST           = rst_b[psrc_pkg::TMR_LSB +: 4];
    assign O_TWO_WIRE_ZERO_RST    = rst_b[psrc_pkg::TW0_BIT];
    assign O_TWO_WIRE_ONE_RST     = rst_b[psrc_pkg::TW1_BIT];
    assign O_SYNC_SERIAL_ZERO_RST = rst_b[psrc_pkg::SSI_LSB];
    assign O_SYNC_SERIAL_ONE_RST  = rst_b[psrc_pkg::SSI_LSB + 1];
    assign O_ASYNC_SERIAL_RST     = rst_b[psrc_pkg::ASY_LSB +: 3];

    // Peripheral reset mapping of control C
    assign O_USB_UNIT_RST   = rst_c[psrc_pkg::USB_BIT];
    assign O_DMA_ENGINE_RST = rst_c[psrc_pkg::DMA_BIT];
    assign O_PORT_RST       = rst_c[psrc_pkg::PORT_LSB +: 8];
endmodule
`default_nettype wire

/* psrc_props.sv */
// Checker for bus answers and reset pin timing at the top ports
`timescale 1ns/1ps
`default_nettype none
module psrc_props (
    input wire logic        I_CORE_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_HSEL,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic        I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    input wire logic [3:0]  O_GP_TMR_RST,
    input wire logic [2:0]  O_ASYNC_SERIAL_RST,
    input wire logic [7:0]  O_PORT_RST
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    logic        take;
    logic        wa_r;
    logic        wd_r;
    logic [14:0] pins;
    // Pins may only move one edge after a write data phase
    assign take = I_HSEL && I_HREADY && I_HTRANS[1];
    assign pins = {O_GP_TMR_RST, O_ASYNC_SERIAL_RST, O_PORT_RST};
    always_ff @(posedge I_CORE_CLK) begin
        wa_r <= I_RST_N && take && I_HWRITE;
        wd_r <= I_RST_N && wa_r;
    end
    spare_zero_a: assert property ((O_HRDATA & 32'hFCF0_8F00) == 32'h0)
        else $error("unused bit reads one");
    rst_pins_a: assert property (disable iff (1'h0)
        !I_RST_N |=> pins == 15'h0) else $error("pins not cleared by reset");
    rst_rdata_a: assert property (disable iff (1'h0)
        !I_RST_N |=> O_HRDATA == 32'h0) else $error("read data not cleared");
    pins_hold_a: assert property (!wd_r |=> $stable(pins))
        else $error("pins moved without a write");
    pins_move_a: assert property ($changed(pins) |-> $past(wd_r))
        else $error("pins moved at wrong edge");
    rdata_hold_a: assert property (!(take && !I_HWRITE) |=>
        $stable(O_HRDATA)) else $error("read data moved without a read");
    resp_okay_a: assert property (!O_HRESP)
        else $error("error response seen");
    ready_high_a: assert property (O_HREADYOUT)
        else $error("wait state inserted");
    cover property (wd_r ##1 pins != 15'h0);
    cover property (take && !I_HWRITE);
    cover property (disable iff (1'h0) $rose(I_RST_N));
endmodule
bind psrc_top psrc_props psrc_props_i (.*);
`default_nettype wire

/* psrc_tb_top.sv */
// Bench driving the reset controls over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module psrc_tb_top;
    // Narrowed masks so that capability gating is really exercised
    localparam logic [31:0] CB = 32'h030F_5037 & 32'h02FF_EFFE;
    localparam logic [31:0] CD = 32'h0001_20FF & 32'h0000_FF7F;
    localparam logic [11:0] RB = psrc_pkg::RST_CTL_B_OFFSET;
    localparam logic [11:0] RC = psrc_pkg::RST_CTL_C_OFFSET;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  hsize = psrc_pkg::HSIZE_WORD;
    logic        resp;
    logic [31:0] hrdata, pb, pc, rd, d;
    logic        rdy, cmp0, cmp1, tw0, tw1, ss0, ss1, usb, dma;
    logic [3:0]  tmr;
    logic [2:0]  asy;
    logic [7:0]  port;
    int          fail_count = 0;
    int          compares = 0;
    always #25 clk = ~clk;
    // Pins gathered back into register layout
    assign pb = {6'h00, cmp1, cmp0, 4'h0, tmr, 1'h0, tw1, 1'h0, tw0,
                 6'h00, ss1, ss0, 1'h0, asy};
    assign pc = {15'h0000, usb, 2'h0, dma, 5'h00, port};
    psrc_top #(.CAP_B(CB), .CAP_D(CD)) psrc_top_i (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
        .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata),
        .O_HREADYOUT(rdy), .O_HRESP(resp), .O_COMPARATOR_ZERO_RST(cmp0),
        .O_COMPARATOR_ONE_RST(cmp1), .O_GP_TMR_RST(tmr),
        .O_TWO_WIRE_ZERO_RST(tw0), .O_TWO_WIRE_ONE_RST(tw1),
        .O_SYNC_SERIAL_ZERO_RST(ss0), .O_SYNC_SERIAL_ONE_RST(ss1),
        .O_ASYNC_SERIAL_RST(asy), .O_USB_UNIT_RST(usb),
        .O_DMA_ENGINE_RST(dma), .O_PORT_RST(port));
    // One single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] v);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= psrc_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (rdy !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge clk); while (rdy !== 1'h1);
        rd = hrdata;
    endtask
    // Readback and pins must agree with the expected word
    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        `CHK(rd, e)
        `CHK((a == RC) ? pc : pb, e)
        `CHK(resp, 1'h0)
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        chk(RB, 32'h0);
        chk(RC, 32'h0);
        // Walking one over every bit, then all ones
        for (int i = 0; i <= 32; i++) begin
            d = (i == 32) ? 32'hFFFF_FFFF : 32'h1 << i;
            xfer(1'h1, RB, d);
            xfer(1'h1, RC, d);
            chk(RB, d & 32'h030F_5037 & CB);
            chk(RC, d & 32'h0001_20FF & CD);
        end
        xfer(1'h1, 12'h04C, 32'h0);
        xfer(1'h1, psrc_pkg::CAP_MASK_B_OFFSET, 32'h0);
        chk(RB, CB);
        // Sub-word transfers are ignored, so the register must not move
        hsize <= 3'h0;
        xfer(1'h1, RB, 32'h0);
        hsize <= psrc_pkg::HSIZE_WORD;
        chk(RB, CB);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        `CHK({pb, pc}, 64'h0)
        rst_n <= 1'h1;
        chk(RC, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
